// file: verilog/mbr_pkg.sv
/*
  Constants and types shared by the Modbus mapping-register responder.
  Assumes a single 100 MHz clock domain and byte-wide frame streams.
*/
// Operation
// RULE1 - Answer only own address, 1 to 247
// RULE2 - Read request: addr, 03, start, qty, CRC
// RULE3 - Mapping window spans 4E20H to 501CH
// RULE4 - Byte count equals twice register quantity
// RULE5 - Read reply: addr, func, count, data, CRC
// RULE6 - CRC-16 low byte first, checked before acting
// RULE7 - Write 06 echoes request after success
// RULE8 - Forward written value to RS485 slave
// RULE9 - Decimal 20000 maps to wire 4E20H
// RULE10 - Multi-register write uses function 16; code serves only 03 and 06
// RULE11 - Drop bad CRC/address; exceptions otherwise
package mbr_pkg;

  // ==========================================================================
  // Frame constants
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE1 = 8'h06;
  localparam logic [7:0] FN_WRITEN = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] ADDR_MIN = 8'h01;
  localparam logic [7:0] ADDR_MAX = 8'hF7;
  localparam logic [15:0] MAP_FIRST = 16'h4E20;
  localparam logic [15:0] MAP_LAST = 16'h501C;
  localparam int MAP_WORDS = 509;
  localparam int MAP_AW = 9;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [2:0] REQ_LEN = 3'h6;
  localparam logic [7:0] QTY_MAX = 8'h7D;

  // ==========================================================================
  // Responder states
  typedef enum logic [5:0] {
    ST_RX   = 6'h01,
    ST_EXEC = 6'h02,
    ST_READ = 6'h04,
    ST_TX   = 6'h08,
    ST_CRC  = 6'h10,
    ST_SKIP = 6'h20
  } mbr_state_t;

endpackage

// file: verilog/mbr_crc_if.sv
/*
  Interface carrying the CRC engine controls between responder modules.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface mbr_crc_if;
  logic clear;
  logic step;
  logic [7:0] data;
  logic [15:0] crc;
  modport engine (input clear, input step, input data, output crc);
  modport user (output clear, output step, output data, input crc);
endinterface

// file: verilog/mbr_crc16.sv
/*
  Byte-serial Modbus CRC-16 engine, one byte per enabled cycle.
  Assumes the user clears it before each frame.
*/
`timescale 1ns/1ps
module mbr_crc16 (
  // Clock and reset
  input wire logic refClk,
  input wire logic nrst,
  input wire logic clkEn,
  // Control
  mbr_crc_if.engine crcIf
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbr_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    crc_d = crc_q;
    if (crcIf.clear) begin
      crc_d = mbr_pkg::CRC_INIT;
    end else if (crcIf.step) begin
      crc_d = crcByte(crc_q, crcIf.data); // RULE6
    end
  end

  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      crc_q <= mbr_pkg::CRC_INIT;
    end else if (clkEn) begin
      crc_q <= crc_d;
    end
  end

  assign crcIf.crc = crc_q;

endmodule

// file: verilog/mbr_responder.sv
/*
  Modbus RTU responder for the 16-bit mapping register window.
  Serves function 03 reads and 06 writes, forwards writes downstream.
  Assumes a framer outside marks frame ends and paces transmit bytes.
*/
`timescale 1ns/1ps
module mbr_responder (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Configuration
  input wire logic [7:0] slaveAddr,
  // Receive byte stream
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxEnd,
  // Transmit byte stream
  output logic txValid,
  output logic [7:0] txData,
  output logic txLast,
  input wire logic txReady,
  // Downstream RS485 forward
  output logic fwdValid,
  output logic [15:0] fwdAddr,
  output logic [15:0] fwdData,
  input wire logic fwdReady,
  // Status
  output logic busy
);

  // ==========================================================================
  // Storage and CRC engine
  logic [15:0] mapMem [mbr_pkg::MAP_WORDS];
  mbr_crc_if crcIf ();

  mbr_crc16 uCrc (
    .refClk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .crcIf(crcIf.engine)
  );

  mbr_pkg::mbr_state_t state_q, state_d;
  logic [7:0] hdr_q [8];
  logic [7:0] hdr_d [8];
  logic [3:0] rxCnt_q, rxCnt_d;
  logic [7:0] txCnt_q, txCnt_d;
  logic [7:0] txLen_q, txLen_d;
  logic [8:0] rdIdx_q, rdIdx_d;
  logic [15:0] rdWord_q, rdWord_d;
  logic [7:0] excCode_q, excCode_d;
  logic txValid_q, txValid_d;
  logic [7:0] txData_q, txData_d;
  logic txLast_q, txLast_d;
  logic fwdValid_q, fwdValid_d;
  logic [15:0] fwdAddr_q, fwdAddr_d;
  logic [15:0] fwdData_q, fwdData_d;
  logic busy_q, busy_d;
  logic memWe;
  logic [8:0] memIdx;
  logic [15:0] regAddr, regArg, lastAddr;
  logic crcOk, inWindow;

  // Wire register address 4E20H stands for decimal mapping address 20000.
  function automatic logic [8:0] mapIndex(input logic [15:0] a);
    logic [15:0] d;
    d = a - mbr_pkg::MAP_FIRST; // RULE9
    return d[8:0];
  endfunction

  assign regAddr = {hdr_q[2], hdr_q[3]};
  assign regArg = {hdr_q[4], hdr_q[5]};
  assign lastAddr = regAddr + regArg - 16'h0001;
  // The CRC of a frame including its own CRC bytes is zero.
  assign crcOk = (crcIf.crc == 16'h0000) && (rxCnt_q == 4'h8); // RULE6
  assign inWindow = (regAddr >= mbr_pkg::MAP_FIRST) && (regAddr <= mbr_pkg::MAP_LAST); // RULE3

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_d = state_q;
    hdr_d = hdr_q;
    rxCnt_d = rxCnt_q;
    txCnt_d = txCnt_q;
    txLen_d = txLen_q;
    rdIdx_d = rdIdx_q;
    rdWord_d = rdWord_q;
    excCode_d = excCode_q;
    txValid_d = txValid_q;
    txData_d = txData_q;
    txLast_d = txLast_q;
    fwdValid_d = fwdValid_q && !fwdReady;
    fwdAddr_d = fwdAddr_q;
    fwdData_d = fwdData_q;
    memWe = 1'b0;
    memIdx = mapIndex(regAddr);
    crcIf.clear = 1'b0;
    crcIf.step = 1'b0;
    crcIf.data = rxData;
    case (state_q)
      mbr_pkg::ST_RX: begin
        if (rxEnd) begin
          state_d = mbr_pkg::ST_EXEC;
        end else if (rxValid) begin
          crcIf.step = 1'b1;
          if (rxCnt_q < 4'h8) begin
            hdr_d[rxCnt_q[2:0]] = rxData;
            rxCnt_d = rxCnt_q + 4'h1;
          end else begin
            rxCnt_d = 4'h9;
          end
        end
      end
      mbr_pkg::ST_EXEC: begin
        excCode_d = 8'h00;
        rxCnt_d = 4'h0;
        crcIf.clear = 1'b1;
        state_d = mbr_pkg::ST_RX;
        // Foreign address, broadcast or bad CRC: drop without reply.
        if (crcOk && hdr_q[0] == slaveAddr && slaveAddr >= mbr_pkg::ADDR_MIN
            && slaveAddr <= mbr_pkg::ADDR_MAX) begin // RULE1 RULE11
          state_d = mbr_pkg::ST_TX;
          txCnt_d = 8'h00;
          if (hdr_q[1] == mbr_pkg::FN_READ) begin // RULE2
            if (regArg == 16'h0000 || regArg > {8'h00, mbr_pkg::QTY_MAX}) begin
              excCode_d = mbr_pkg::EXC_VALUE;
            end else if (!inWindow || lastAddr > mbr_pkg::MAP_LAST) begin
              excCode_d = mbr_pkg::EXC_ADDR; // RULE11
            end else begin
              state_d = mbr_pkg::ST_READ;
              rdIdx_d = mapIndex(regAddr);
              txLen_d = 8'h03 + {regArg[6:0], 1'b0}; // RULE4
            end
          end else if (hdr_q[1] == mbr_pkg::FN_WRITE1) begin // RULE7
            if (!inWindow) begin
              excCode_d = mbr_pkg::EXC_ADDR; // RULE11
            end else if (fwdValid_q) begin
              state_d = mbr_pkg::ST_RX; // Forward port still busy; master retries.
            end else begin
              memWe = 1'b1;
              fwdValid_d = 1'b1; // RULE8
              fwdAddr_d = regAddr;
              fwdData_d = regArg;
              txLen_d = {4'h0, 1'b0, mbr_pkg::REQ_LEN};
            end
          end else begin
            // Multi-register write (16) is not served here and answers illegal function.
            excCode_d = mbr_pkg::EXC_FUNC; // RULE10 RULE11
          end
          if (excCode_d != 8'h00) begin
            txLen_d = 8'h03;
          end
        end
      end
      mbr_pkg::ST_READ: begin
        memIdx = rdIdx_q;
        rdWord_d = mapMem[rdIdx_q];
        state_d = mbr_pkg::ST_TX;
        // A byte taken while the next word is fetched must not be offered twice.
        if (txReady) begin
          txValid_d = 1'b0;
        end
      end
      mbr_pkg::ST_TX: begin
        if (!txValid_q || txReady) begin
          txValid_d = 1'b1;
          txLast_d = 1'b0;
          if (txCnt_q == 8'h00) begin
            txData_d = hdr_q[0];
          end else if (txCnt_q == 8'h01) begin
            txData_d = (excCode_q != 8'h00) ? (hdr_q[1] | mbr_pkg::EXC_FLAG) : hdr_q[1];
          end else if (excCode_q != 8'h00) begin
            txData_d = excCode_q;
          end else if (hdr_q[1] == mbr_pkg::FN_WRITE1) begin
            txData_d = hdr_q[txCnt_q[2:0]]; // RULE7
          end else if (txCnt_q == 8'h02) begin
            txData_d = {regArg[6:0], 1'b0}; // RULE4
          end else if (txCnt_q[0]) begin
            txData_d = rdWord_q[15:8]; // RULE5
          end else begin
            txData_d = rdWord_q[7:0];
            rdIdx_d = rdIdx_q + 9'h001;
          end
          crcIf.step = 1'b1;
          crcIf.data = txData_d;
          txCnt_d = txCnt_q + 8'h01;
          if (txCnt_d == txLen_q) begin
            state_d = mbr_pkg::ST_CRC;
          end else if (hdr_q[1] == mbr_pkg::FN_READ && excCode_q == 8'h00
                       && txCnt_q >= 8'h03 && !txCnt_q[0]) begin
            state_d = mbr_pkg::ST_READ;
          end
        end
      end
      mbr_pkg::ST_CRC: begin
        if (txReady) begin
          txValid_d = 1'b1;
          if (!txLast_q && txCnt_q == txLen_q) begin
            txData_d = crcIf.crc[7:0]; // RULE6
            txCnt_d = txCnt_q + 8'h01;
          end else if (!txLast_q) begin
            txData_d = crcIf.crc[15:8];
            txLast_d = 1'b1;
          end else begin
            txValid_d = 1'b0;
            txLast_d = 1'b0;
            state_d = mbr_pkg::ST_SKIP;
          end
        end
      end
      mbr_pkg::ST_SKIP: begin
        crcIf.clear = 1'b1;
        rxCnt_d = 4'h0;
        state_d = mbr_pkg::ST_RX;
      end
      default: begin
        state_d = mbr_pkg::ST_SKIP;
      end
    endcase
    // Busy is registered so that the status pin comes from a flip-flop.
    busy_d = (state_d != mbr_pkg::ST_RX);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= mbr_pkg::ST_SKIP;
      for (int i = 0; i < 8; i++) begin
        hdr_q[i] <= 8'h00;
      end
      rxCnt_q <= 4'h0;
      txCnt_q <= 8'h00;
      txLen_q <= 8'h00;
      rdIdx_q <= 9'h000;
      rdWord_q <= 16'h0000;
      excCode_q <= 8'h00;
      txValid_q <= 1'b0;
      txData_q <= 8'h00;
      txLast_q <= 1'b0;
      fwdValid_q <= 1'b0;
      fwdAddr_q <= 16'h0000;
      fwdData_q <= 16'h0000;
      busy_q <= 1'b1;
    end else if (clkEn) begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      rxCnt_q <= rxCnt_d;
      txCnt_q <= txCnt_d;
      txLen_q <= txLen_d;
      rdIdx_q <= rdIdx_d;
      rdWord_q <= rdWord_d;
      excCode_q <= excCode_d;
      txValid_q <= txValid_d;
      txData_q <= txData_d;
      txLast_q <= txLast_d;
      fwdValid_q <= fwdValid_d;
      fwdAddr_q <= fwdAddr_d;
      fwdData_q <= fwdData_d;
      busy_q <= busy_d;
    end
  end

  // The mapping store has no reset; a memory this size would cost a wide clear.
  always_ff @(posedge ref_clk) begin
    if (clkEn && memWe) begin
      mapMem[memIdx] <= regArg;
    end
  end

  assign txValid = txValid_q;
  assign txData = txData_q;
  assign txLast = txLast_q;
  assign fwdValid = fwdValid_q;
  assign fwdAddr = fwdAddr_q;
  assign fwdData = fwdData_q;
  assign busy = busy_q;

endmodule

// file: verification/mbr_responder_sva.sv
/*
  Port checker for the Modbus mapping-register responder.
  Assumes it is bound to every mbr_responder instance and sees only its ports.
*/
`timescale 1ns/1ps
module mbr_responder_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration
  input wire logic [7:0] slaveAddr,
  // Transmit byte stream
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  input wire logic txReady,
  // Downstream forward
  input wire logic fwdValid,
  input wire logic [15:0] fwdAddr,
  input wire logic [15:0] fwdData,
  input wire logic fwdReady,
  // Status
  input wire logic busy
);
  // ==========================================================================
  // Byte position within the reply, counted on accepted bytes
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  always_comb idx_d = (txValid && txReady) ? (txLast ? 8'h00 : idx_q + 8'h01) : idx_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idx_q <= 8'h00;
    end else begin
      idx_q <= idx_d;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte changed before it was taken");
  a_first_addr: assert property (txValid && idx_q == 8'h00 |-> txData == slaveAddr)
    else $error("reply does not start with own address");
  a_min_frame: assert property (txValid && txLast |-> idx_q >= 8'h04)
    else $error("reply too short to carry a check word");
  a_last_gap: assert property (txValid && txReady && txLast |=> !txValid)
    else $error("byte offered right after the final check byte");
  a_tx_busy: assert property (txValid |-> busy)
    else $error("reply byte offered while idle");
  a_fwd_hold: assert property (fwdValid && !fwdReady |=> fwdValid && $stable(fwdAddr) && $stable(fwdData))
    else $error("forward request changed before it was taken");
  a_fwd_window: assert property (fwdValid |-> fwdAddr >= 16'h4E20 && fwdAddr <= 16'h501C)
    else $error("forward address outside the mapping window");
  a_exc_len: assert property (txValid && txReady && idx_q == 8'h01 && txData[7]
    |-> ##[1:40] (txValid && txReady && txLast && idx_q == 8'h04))
    else $error("exception reply is not five bytes");
  c_reply: cover property (txValid && txReady && txLast);
  c_fwd: cover property (fwdValid && fwdReady);
  c_stall: cover property (txValid && !txReady);
endmodule

bind mbr_responder mbr_responder_sva chk (.ref_clk, .nrst, .slaveAddr, .txValid, .txData,
  .txLast, .txReady, .fwdValid, .fwdAddr, .fwdData, .fwdReady, .busy);

// file: verification/mbr_master_model.sv
/*
  Remote master model: sends request frames with check word, takes replies.
  Assumes one clock; all outputs change on the falling edge.
*/
`timescale 1ns/1ps
module mbr_master_model (
  // Clock
  input wire logic ref_clk,
  // Request stream
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxEnd,
  // Reply stream
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady,
  // Downstream forward
  input wire logic fwdValid,
  input wire logic [15:0] fwdAddr,
  input wire logic [15:0] fwdData,
  output logic fwdReady
);
  // ==========================================================================
  // State
  logic [7:0] r [0:15];
  int rn = 0;
  int fn = 0;
  bit slow = 1'h0;
  logic [15:0] fa;
  logic [15:0] fd;
  initial begin
    rxValid = 1'h0;
    rxData = 8'h00;
    rxEnd = 1'h0;
    txReady = 1'h1;
    fwdReady = 1'h0;
  end
  // The downstream side accepts half a cycle late, never at once.
  always @(negedge ref_clk) fwdReady <= fwdValid && !fwdReady;
  always @(posedge ref_clk) begin
    if (fwdValid && fwdReady) begin
      fa <= fwdAddr;
      fd <= fwdData;
      fn <= fn + 1;
    end
  end

  // ==========================================================================
  // Frame tasks
  function automatic logic [15:0] crc16(input logic [63:0] b, input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, b[8*(n-1-i)+:8]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // Body bytes go out first to last; a bad frame has its check word inverted.
  task automatic send(input logic [63:0] b, input int n, input bit bad);
    logic [15:0] c;
    c = bad ? ~crc16(b, n) : crc16(b, n);
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < n + 2; i++) begin
      @(negedge ref_clk);
      rxValid = 1'h1;
      rxData = i < n ? b[8*(n-1-i)+:8] : (i == n ? c[7:0] : c[15:8]);
      @(negedge ref_clk);
      rxValid = 1'h0;
      rxData = ~rxData;
    end
    rxEnd = 1'h1;
    @(negedge ref_clk);
    rxEnd = 1'h0;
  endtask
  // Ready is set before the byte is recorded, so the record matches the next edge.
  task automatic recv(input int bound);
    rn = 0;
    for (int k = 0; k < bound; k++) begin
      @(negedge ref_clk);
      txReady = slow ? ~txReady : 1'h1;
      if (txValid && txReady && rn < 16) begin
        r[rn] = txData;
        rn++;
        if (txLast) break;
      end
    end
  endtask
endmodule

// file: verification/tb_modbus_mapping_register_responder.sv
/*
  Self-checking bench for the mapping-register responder.
  Assumes the master model and the bound port checker.
*/
`timescale 1ns/1ps
module tb_modbus_mapping_register_responder;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic clkEn = 1'h1;
  logic [7:0] slaveAddr = 8'hF7;
  logic rxValid, rxEnd, txValid, txLast, txReady, fwdValid, fwdReady, busy;
  logic [7:0] rxData, txData;
  logic [15:0] fwdAddr, fwdData;
  int errors = 0;
  int n_checks = 0;
  always #5 ref_clk = ~ref_clk;
  mbr_responder dut (.ref_clk, .nrst, .clkEn, .slaveAddr, .rxValid, .rxData, .rxEnd, .txValid,
    .txData, .txLast, .txReady, .fwdValid, .fwdAddr, .fwdData, .fwdReady, .busy);
  mbr_master_model master (.ref_clk, .rxValid, .rxData, .rxEnd, .txValid, .txData, .txLast,
    .txReady, .fwdValid, .fwdAddr, .fwdData, .fwdReady);

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A reply of n body bytes is expected; n of zero means silence.
  task automatic xfer(input logic [63:0] q, input int qn, input bit bad, input logic [63:0] p,
      input int n);
    logic [15:0] c;
    master.send(q, qn, bad);
    master.recv(n > 0 ? 300 : 40);
    if (n > 0 && master.rn == 0) begin
      errors++;
      tally_and_finish();
    end
    c = master.crc16(p, n);
    check("reply length", 16'(master.rn), 16'(n == 0 ? 0 : n + 2));
    for (int i = 0; i < n; i++) check("reply byte", master.r[i], p[8*(n-1-i)+:8]);
    if (n > 0) begin
      check("check low", master.r[n], c[7:0]);
      check("check high", master.r[n+1], c[15:8]);
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_write;
    xfer({8'hF7, 8'h06, 16'h4E20, 16'h0064}, 6, 0, {8'hF7, 8'h06, 16'h4E20, 16'h0064}, 6);
    check("fwd addr", master.fa, 16'h4E20);
    check("fwd data", master.fd, 16'h0064);
    master.slow = 1'h1;
    xfer({8'hF7, 8'h06, 16'h501C, 16'hABCD}, 6, 0, {8'hF7, 8'h06, 16'h501C, 16'hABCD}, 6);
    check("fwd data", master.fd, 16'hABCD);
    master.slow = 1'h0;
    $display("test write done");
  endtask
  task automatic t_read;
    xfer({8'hF7, 8'h06, 16'h4E21, 16'h1234}, 6, 0, {8'hF7, 8'h06, 16'h4E21, 16'h1234}, 6);
    xfer({8'hF7, 8'h03, 16'h4E20, 16'h0002}, 6, 0, {8'hF7, 8'h03, 8'h04, 32'h0064_1234}, 7);
    master.slow = 1'h1;
    xfer({8'hF7, 8'h03, 16'h501C, 16'h0001}, 6, 0, {8'hF7, 8'h03, 8'h02, 16'hABCD}, 5);
    master.slow = 1'h0;
    $display("test read done");
  endtask
  task automatic t_drop;
    int fn0;
    fn0 = master.fn;
    xfer({8'hF7, 8'h06, 16'h4E22, 16'h5555}, 6, 1, 64'h0, 0);
    xfer({8'h01, 8'h06, 16'h4E22, 16'h5555}, 6, 0, 64'h0, 0);
    check("fwd count", 16'(master.fn), 16'(fn0));
    $display("test drop done");
  endtask
  task automatic t_exc;
    xfer({8'hF7, 8'h04, 16'h4E20, 16'h0001}, 6, 0, {8'hF7, 8'h84, 8'h01}, 3);
    xfer({8'hF7, 8'h03, 16'h501D, 16'h0001}, 6, 0, {8'hF7, 8'h83, 8'h02}, 3);
    xfer({8'hF7, 8'h03, 16'h501C, 16'h0002}, 6, 0, {8'hF7, 8'h83, 8'h02}, 3);
    xfer({8'hF7, 8'h03, 16'h4E20, 16'h0000}, 6, 0, {8'hF7, 8'h83, 8'h03}, 3);
    xfer({8'hF7, 8'h06, 16'h4E1F, 16'h0001}, 6, 0, {8'hF7, 8'h86, 8'h02}, 3);
    xfer({8'hF7, 8'h10, 16'h4E20, 16'h0001}, 6, 0, {8'hF7, 8'h90, 8'h01}, 3);
    $display("test exception done");
  endtask
  // A frozen block must ignore a whole frame and resume cleanly afterwards.
  task automatic t_freeze;
    repeat (4) @(negedge ref_clk);
    clkEn = 1'h0;
    xfer({8'hF7, 8'h03, 16'h4E20, 16'h0001}, 6, 0, 64'h0, 0);
    clkEn = 1'h1;
    check("busy", 16'(busy), 16'h0000);
    xfer({8'hF7, 8'h03, 16'h4E20, 16'h0001}, 6, 0, {8'hF7, 8'h03, 8'h02, 16'h0064}, 5);
    $display("test freeze done");
  endtask

  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'h1;
    repeat (3) @(negedge ref_clk);
    t_write();
    t_read();
    t_drop();
    t_exc();
    t_freeze();
    tally_and_finish();
  end
endmodule
